// ==== hw/osd_pkg.sv ====
// shared constants and types for the oscillator select and clock divider
package osd_pkg;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_CTL = 4'h0; // oscillator_control
  localparam logic [3:0] ADDR_DIV = 4'h1; // clock_divisor
  localparam logic [3:0] ADDR_KEY = 4'h2; // unlock key port, reads zero

  // unlock keys: arbitrary values, two words per byte half
  localparam logic [15:0] KEY_H1 = 16'hA5C3;
  localparam logic [15:0] KEY_H2 = 16'h3CA5;
  localparam logic [15:0] KEY_L1 = 16'h5AC3;
  localparam logic [15:0] KEY_L2 = 16'hC35A;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_CSRC = 12;
  localparam int CTL_NSRC = 8;
  localparam int CTL_SRCLK = 7;
  localparam int CTL_RMPLK = 6;
  localparam int CTL_LOCK = 5;
  localparam int CTL_FAIL = 3;
  localparam int CTL_LPOSC = 1;
  localparam int CTL_REQ = 0;
  localparam int DIV_RCV = 15;
  localparam int DIV_DOZE = 12;
  localparam int DIV_RDEN = 11;
  localparam int DIV_POST = 8;

  // ----------------------------------------
  // source codes, submodes, monitor settings
  // ----------------------------------------
  localparam logic [2:0] SRC_RC = 3'h0;
  localparam logic [2:0] SRC_RCMUL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRIPLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOWRC = 3'h5;
  localparam logic [2:0] SRC_RC16 = 3'h6;
  localparam logic [2:0] SRC_RCDIVN = 3'h7;
  localparam logic [1:0] PM_EXT = 2'h0;
  localparam logic [1:0] PM_MED = 2'h1;
  localparam logic [1:0] PM_HIGH = 2'h2;
  localparam logic [1:0] MON_BOTH = 2'h0;
  localparam logic [1:0] MON_SW_ONLY = 2'h1;

  // ----------------------------------------
  // reset values and timing counts
  // ----------------------------------------
  localparam logic [2:0] DOZE_RST = 3'h3;
  localparam logic [2:0] POST_RST = 3'h0;
  localparam logic [2:0] CODE_ONE = 3'h0;
  localparam int SETTLE_CYCLES = 10;
  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);
  localparam logic [1:0] CFG_LOAD_AT = 2'h2;

  // configuration settings arriving from nonvolatile storage
  typedef struct packed {
    logic [2:0] init_src;
    logic [1:0] submode;
    logic [1:0] monitor;
  } osd_cfg_t;

  // clock tree controls toward the analog side
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] submode;
    logic primary_en;
    logic pll_en;
    logic sec_en;
  } osd_clk_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SETTLE = 3'b100
  } osd_sw_state_t;

endpackage : osd_pkg

// ==== hw/osd_ratio_div.sv ====
// tick divider by a power of two chosen by a 3-bit code
`timescale 1ns/1ps
module osd_ratio_div #(
  parameter int CNT_W = 8,
  parameter bit TOP_256 = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [2:0] code,
  input wire logic tick_in,
  output logic tick_out
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (CNT_W < 8) begin : g_bad_width
    $error("osd_ratio_div needs CNT_W of at least 8");
  end

  logic [CNT_W-1:0] cnt_q; // input ticks seen in this period
  logic [CNT_W:0] div_w; // divisor, one bit wider for 256
  logic [CNT_W-1:0] lim_w; // last count of the period

  // ----------------------------------------
  // divisor lookup
  // ----------------------------------------
  always_comb begin
    div_w = (CNT_W+1)'(1) << code;
    // top code jumps to 256 on the rc postscaler
    if (TOP_256 && code == 3'h7) begin
      div_w = (CNT_W+1)'(256);
    end
    lim_w = CNT_W'(div_w - (CNT_W+1)'(1));
  end

  // ----------------------------------------
  // counter; >= guards a code that shrinks mid-period
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (cnt_q >= lim_w);
      if (tick_in) begin
        cnt_q <= (cnt_q >= lim_w) ? '0 : cnt_q + CNT_W'(1);
      end
    end
  end

endmodule : osd_ratio_div

// ==== hw/osd_clock_ctl.sv ====
// oscillator source select, switch sequencer and clock ratio control
//
// Contract
// R01: power-on source from 3-bit initial setting
// R02: primary submode chosen by 2-bit setting
// R03: erased device starts fast RC divided
// R04: current source read-only at bits 14-12
// R05: next source writable, loaded from settings
// R06: request bit set by software, hardware clears
// R07: clock lock bit blocks switching in 01
// R08: pin remap lock rejects remap writes
// R09: PLL lock status reads locked state
// R10: clock fail flag set, software clears
// R11: bit 1 enables secondary oscillator
// R12: control writes need unlock sequence first
// R13: software passes plain fast RC between PLLs
// R14: interrupt clears reduction enable when recover set
// R15: reduction field divides 1 to 128
// R16: reduction enable selects ratio, else 1:1
// R17: reduction field frozen while enable set
// R18: enable cannot set while field 000
// R19: postscaler divides 1 to 256
// R20: unimplemented bits read as zero
// R21: same-source request aborts and clears
// R22: valid switch clears lock and fail flags
// R23: wait ready, ten cycles, then commit
// R24: failure traps and falls to fast RC
// R25: two-word key arms one following write
// R26: request held zero when switching disabled
`timescale 1ns/1ps
module osd_clock_ctl (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire osd_pkg::osd_cfg_t cfg,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic osc_ready_pin,
  input wire logic pll_lock_pin,
  input wire logic new_src_clk,
  input wire logic clk_fail_pin,
  input wire logic irq_event,
  input wire logic fcy_tick,
  input wire logic rc_tick,
  input wire logic remap_wr_req,
  output logic remap_wr_ok,
  output osd_pkg::osd_clk_t clk_out,
  output logic fail_trap,
  output logic cpu_tick,
  output logic rc_post_tick
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_pll(input logic [2:0] s);
    is_pll = (s == osd_pkg::SRC_PRIPLL) || (s == osd_pkg::SRC_RCMUL);
  endfunction : is_pll

  function automatic logic is_pri(input logic [2:0] s);
    is_pri = (s == osd_pkg::SRC_PRI) || (s == osd_pkg::SRC_PRIPLL);
  endfunction : is_pri

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [10:0] s1_q; // first stage, read only by s2_q
  logic [10:0] s2_q; // second stage
  logic [1:0] s3_q; // edge history: new clock, fail
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {cfg, osc_ready_pin, pll_lock_pin, new_src_clk, clk_fail_pin};
      s2_q <= s1_q;
      s3_q <= {s2_q[1], s2_q[0]};
    end
  end

  osd_pkg::osd_cfg_t cfg_s; // settings after sync
  logic rdy_s; // oscillator start-up timer done
  logic pll_s; // analog PLL lock
  logic new_tick; // one edge of the new source
  logic fail_evt; // rising failure while monitor on
  logic mon_en;
  assign cfg_s = osd_pkg::osd_cfg_t'(s2_q[10:4]);
  assign rdy_s = s2_q[3];
  assign pll_s = s2_q[2];
  assign new_tick = s2_q[1] && !s3_q[1];
  assign fail_evt = mon_en && s2_q[0] && !s3_q[0];

  // ----------------------------------------
  // settings capture after reset release
  // ----------------------------------------
  // settings are straps: caught once the sync chain is full
  logic [1:0] ld_cnt_q;
  logic ld_done_q;
  logic load_now;
  osd_pkg::osd_cfg_t cfg_q;
  assign load_now = !ld_done_q && (ld_cnt_q == osd_pkg::CFG_LOAD_AT);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ld_cnt_q <= '0;
      ld_done_q <= 1'b0;
      cfg_q <= '{init_src: osd_pkg::SRC_RCDIVN, submode: osd_pkg::PM_EXT, monitor: 2'h3};
    end else if (!ld_done_q) begin
      ld_cnt_q <= ld_cnt_q + 2'h1;
      if (load_now) begin
        ld_done_q <= 1'b1;
        cfg_q <= cfg_s;
      end
    end
  end

  logic sw_en; // switching enabled by settings
  logic srclk_q;
  logic clk_locked; // lock bit honoured only in switch-only mode
  assign sw_en = ld_done_q && !cfg_q.monitor[1];
  assign mon_en = ld_done_q && (cfg_q.monitor == osd_pkg::MON_BOTH);
  assign clk_locked = (cfg_q.monitor == osd_pkg::MON_SW_ONLY) && srclk_q; // R07

  // ----------------------------------------
  // bus decode and unlock keys
  // ----------------------------------------
  logic wr_ctl, wr_div, wr_key;
  logic key1_hi_q, key1_lo_q, arm_hi_q, arm_lo_q;
  logic hi_ok, lo_ok; // byte halves that may be written now
  assign wr_ctl = reg_wr && (reg_addr == osd_pkg::ADDR_CTL);
  assign wr_div = reg_wr && (reg_addr == osd_pkg::ADDR_DIV);
  assign wr_key = reg_wr && (reg_addr == osd_pkg::ADDR_KEY);
  assign hi_ok = wr_ctl && arm_hi_q; // R12
  assign lo_ok = wr_ctl && arm_lo_q; // R12

  // every write consumes a pending key stage or arm
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      key1_hi_q <= 1'b0;
      key1_lo_q <= 1'b0;
      arm_hi_q <= 1'b0;
      arm_lo_q <= 1'b0;
    end else if (reg_wr) begin
      key1_hi_q <= wr_key && (reg_wdata == osd_pkg::KEY_H1); // R25
      key1_lo_q <= wr_key && (reg_wdata == osd_pkg::KEY_L1); // R25
      arm_hi_q <= wr_key && key1_hi_q && (reg_wdata == osd_pkg::KEY_H2); // R25
      arm_lo_q <= wr_key && key1_lo_q && (reg_wdata == osd_pkg::KEY_L2); // R25
    end
  end

  // ----------------------------------------
  // switch sequencer
  // ----------------------------------------
  osd_pkg::osd_sw_state_t st_q;
  logic [2:0] csrc_q, nsrc_q;
  logic req_q, lock_q, fail_q, rmplk_q, lposc_q;
  logic [3:0] cnt_q; // new-source edges in settle
  logic same, start, abort_i, done, ready_ok, need_osc, eff_pll;
  assign same = (nsrc_q == csrc_q);
  assign abort_i = (st_q == osd_pkg::ST_IDLE) && req_q && (same || clk_locked); // R21 R07
  assign start = (st_q == osd_pkg::ST_IDLE) && sw_en && req_q && !same && !clk_locked;
  assign done = (st_q == osd_pkg::ST_SETTLE) && new_tick && (cnt_q == osd_pkg::SETTLE_LAST);
  // crystals wait for start-up, PLL sources for lock
  assign need_osc = (is_pri(nsrc_q) && cfg_q.submode != osd_pkg::PM_EXT) || (nsrc_q == osd_pkg::SRC_SEC);
  assign ready_ok = (!need_osc || rdy_s) && (!is_pll(nsrc_q) || pll_s); // R23
  assign eff_pll = is_pll((st_q == osd_pkg::ST_IDLE) ? csrc_q : nsrc_q);

  // state walk; a failure drops any switch in progress
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= osd_pkg::ST_IDLE;
    end else if (fail_evt) begin
      st_q <= osd_pkg::ST_IDLE; // R24
    end else begin
      unique case (st_q)
        osd_pkg::ST_IDLE: begin
          if (start) st_q <= osd_pkg::ST_WAIT;
        end
        osd_pkg::ST_WAIT: begin
          if (ready_ok) st_q <= osd_pkg::ST_SETTLE; // R23
        end
        osd_pkg::ST_SETTLE: begin
          if (done) st_q <= osd_pkg::ST_IDLE; // R23
        end
        default: st_q <= osd_pkg::ST_IDLE;
      endcase
    end
  end

  // settle counter runs on new-source edges only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (st_q != osd_pkg::ST_SETTLE) begin
      cnt_q <= '0;
    end else if (new_tick) begin
      cnt_q <= cnt_q + 4'h1; // R23
    end
  end

  // request bit: software sets, hardware clears
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_q <= 1'b0;
    end else if (!sw_en) begin
      req_q <= 1'b0; // R26
    end else if (lo_ok) begin
      req_q <= reg_wdata[osd_pkg::CTL_REQ]; // R06
    end else if (done || abort_i || fail_evt) begin
      req_q <= 1'b0; // R06 R21
    end
  end

  // current source: settings, commit, or failure fallback
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      csrc_q <= osd_pkg::SRC_RCDIVN; // R03
    end else if (load_now) begin
      csrc_q <= cfg_s.init_src; // R01
    end else if (fail_evt) begin
      // a PLL system clock keeps the PLL on the rc fallback
      csrc_q <= is_pll(csrc_q) ? osd_pkg::SRC_RCMUL : osd_pkg::SRC_RC; // R24
    end else if (done) begin
      csrc_q <= nsrc_q; // R23
    end
  end

  // next source: settings at power-on, then unlocked writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nsrc_q <= osd_pkg::SRC_RCDIVN; // R03
    end else if (load_now) begin
      nsrc_q <= cfg_s.init_src; // R05
    end else if (hi_ok && sw_en) begin
      nsrc_q <= reg_wdata[osd_pkg::CTL_NSRC +: 3]; // R05 R26
    end
  end

  // status flags; a failure beats the clears
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lock_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      lock_q <= start ? 1'b0 : (eff_pll && pll_s); // R09 R22
      if (fail_evt) begin
        fail_q <= 1'b1; // R10
      end else if (start) begin
        fail_q <= 1'b0; // R22
      end else if (lo_ok && !reg_wdata[osd_pkg::CTL_FAIL]) begin
        fail_q <= 1'b0; // R10
      end
    end
  end

  // plain low-byte control bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      srclk_q <= 1'b0;
      rmplk_q <= 1'b0;
      lposc_q <= 1'b0;
    end else if (lo_ok) begin
      srclk_q <= reg_wdata[osd_pkg::CTL_SRCLK];
      rmplk_q <= reg_wdata[osd_pkg::CTL_RMPLK];
      lposc_q <= reg_wdata[osd_pkg::CTL_LPOSC]; // R11
    end
  end

  assign remap_wr_ok = remap_wr_req && !rmplk_q; // R08

  // ----------------------------------------
  // clock divisor register
  // ----------------------------------------
  logic rcv_q, rden_q;
  logic [2:0] doze_q, post_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rcv_q <= 1'b0;
      doze_q <= osd_pkg::DOZE_RST; // R15
      rden_q <= 1'b0;
      post_q <= osd_pkg::POST_RST; // R19
    end else begin
      if (wr_div) begin
        rcv_q <= reg_wdata[osd_pkg::DIV_RCV];
        post_q <= reg_wdata[osd_pkg::DIV_POST +: 3];
        if (!rden_q) begin
          doze_q <= reg_wdata[osd_pkg::DIV_DOZE +: 3]; // R17
        end
      end
      // the interrupt clear wins over a same-cycle write
      if (irq_event && rcv_q) begin
        rden_q <= 1'b0; // R14
      end else if (wr_div) begin
        rden_q <= reg_wdata[osd_pkg::DIV_RDEN] && (rden_q || doze_q != osd_pkg::CODE_ONE); // R18
      end
    end
  end

  // ----------------------------------------
  // ratio dividers
  // ----------------------------------------
  logic [2:0] cpu_code;
  assign cpu_code = rden_q ? doze_q : osd_pkg::CODE_ONE; // R16

  osd_ratio_div #(.CNT_W(8), .TOP_256(1'b0)) u_cpu_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .code(cpu_code),
    .tick_in(fcy_tick),
    .tick_out(cpu_tick)
  ); // R15

  osd_ratio_div #(.CNT_W(8), .TOP_256(1'b1)) u_rc_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .code(post_q),
    .tick_in(rc_tick),
    .tick_out(rc_post_tick)
  ); // R19

  // ----------------------------------------
  // read data and clock controls
  // ----------------------------------------
  logic [15:0] ctl_w, div_w;
  always_comb begin
    ctl_w = '0; // R20
    ctl_w[osd_pkg::CTL_CSRC +: 3] = csrc_q; // R04
    ctl_w[osd_pkg::CTL_NSRC +: 3] = nsrc_q;
    ctl_w[osd_pkg::CTL_SRCLK] = srclk_q;
    ctl_w[osd_pkg::CTL_RMPLK] = rmplk_q;
    ctl_w[osd_pkg::CTL_LOCK] = lock_q;
    ctl_w[osd_pkg::CTL_FAIL] = fail_q;
    ctl_w[osd_pkg::CTL_LPOSC] = lposc_q;
    ctl_w[osd_pkg::CTL_REQ] = req_q;
    div_w = '0; // R20
    div_w[osd_pkg::DIV_RCV] = rcv_q;
    div_w[osd_pkg::DIV_DOZE +: 3] = doze_q;
    div_w[osd_pkg::DIV_RDEN] = rden_q;
    div_w[osd_pkg::DIV_POST +: 3] = post_q;
  end

  // data stand one cycle after the read, zero otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == osd_pkg::ADDR_CTL) begin
      reg_rdata <= ctl_w;
    end else if (reg_rd && reg_addr == osd_pkg::ADDR_DIV) begin
      reg_rdata <= div_w;
    end else begin
      reg_rdata <= '0;
    end
  end

  // submode only matters for primary sources; the high-speed crystal has no PLL path
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_out <= '{src: osd_pkg::SRC_RCDIVN, submode: osd_pkg::PM_EXT, primary_en: 1'b0,
                   pll_en: 1'b0, sec_en: 1'b0};
      fail_trap <= 1'b0;
    end else begin
      clk_out.src <= csrc_q;
      clk_out.submode <= is_pri(csrc_q) ? cfg_q.submode : osd_pkg::PM_EXT; // R02
      clk_out.primary_en <= is_pri(csrc_q); // R02
      clk_out.pll_en <= is_pll(csrc_q) && !(is_pri(csrc_q) && cfg_q.submode == osd_pkg::PM_HIGH); // R02
      clk_out.sec_en <= lposc_q || (csrc_q == osd_pkg::SRC_SEC); // R11
      fail_trap <= fail_evt; // R24
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence seq_commit;
    done && !fail_evt;
  endsequence

  a_req_held_off: assert property (!sw_en |=> !req_q) else $error("request set while switching off"); // R26
  a_same_abort: assert property (abort_i && !lo_ok && !fail_evt |=> !req_q && st_q == osd_pkg::ST_IDLE) // R21
    else $error("redundant switch not aborted");
  a_start_clears: assert property (start && !fail_evt |=> !lock_q && !fail_q && st_q == osd_pkg::ST_WAIT) // R22
    else $error("switch start left flags set");
  a_commit_copy: assert property (seq_commit |=> csrc_q == $past(nsrc_q) && st_q == osd_pkg::ST_IDLE) // R23
    else $error("commit did not copy next source");
  a_commit_req: assert property (seq_commit and !lo_ok |=> !req_q) else $error("request not cleared on commit"); // R06
  a_locked_ctl: assert property (wr_ctl && !arm_hi_q && ld_done_q |=> $stable(nsrc_q)) // R12
    else $error("locked write changed next source");
  a_fail_flag: assert property (fail_evt |=> fail_q && fail_trap && !csrc_q[2] && !csrc_q[1]) // R24
    else $error("failure not flagged or no fallback");
  a_doze_frozen: assert property (wr_div && rden_q |=> $stable(doze_q)) else $error("doze field changed while on"); // R17
  a_doze_zero: assert property (wr_div && !rden_q && doze_q == osd_pkg::CODE_ONE |=> !rden_q) // R18
    else $error("doze enabled with field zero");
  a_recover_clear: assert property (irq_event && rcv_q |=> !rden_q) else $error("interrupt did not clear doze"); // R14
  a_remap_lock: assert property (rmplk_q |-> !remap_wr_ok) else $error("remap write passed lock"); // R08
  a_div_low_zero: assert property (reg_rd && reg_addr == osd_pkg::ADDR_DIV |=> reg_rdata[7:0] == 8'h00) // R20
    else $error("divisor low byte not zero");

endmodule : osd_clock_ctl

// ==== bench/osd_testbench.sv ====
// self-checking bench for the oscillator select and clock divider
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // stimulus, observed outputs, counters
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  osd_pkg::osd_cfg_t cfg = '0;
  logic [3:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic osc_ready_pin = 1'b1; // start-up timer treated as done
  logic pll_lock_pin = 1'b0;
  logic new_src_clk = 1'b0; // stands still outside a switch
  logic clk_fail_pin = 1'b0;
  logic irq_event = 1'b0;
  logic fcy_tick = 1'b0;
  logic rc_tick = 1'b0;
  logic remap_wr_req = 1'b1; // always asking, so the gate shows
  logic remap_wr_ok;
  osd_pkg::osd_clk_t clk_out;
  logic fail_trap;
  logic cpu_tick;
  logic rc_post_tick;
  logic tick_en = 1'b0; // random ticks only inside the tick window
  int n_fcy = 0, n_cpu = 0, n_rc = 0, n_post = 0;
  int fail_count = 0;
  int num_checks = 0;
  int k;
  int f0, c0, r0, p0; // tick counts at the start of a window
  logic [15:0] d; // last word read
  logic [2:0] dz, fr;

  osd_clock_ctl i_osd_clock_ctl (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_ready_pin(osc_ready_pin), .pll_lock_pin(pll_lock_pin), .new_src_clk(new_src_clk),
    .clk_fail_pin(clk_fail_pin), .irq_event(irq_event), .fcy_tick(fcy_tick), .rc_tick(rc_tick),
    .remap_wr_req(remap_wr_req), .remap_wr_ok(remap_wr_ok), .clk_out(clk_out),
    .fail_trap(fail_trap), .cpu_tick(cpu_tick), .rc_post_tick(rc_post_tick));

  // ----------------------------------------
  // clock and random tick sources
  // ----------------------------------------
  initial forever #25 clk_sys = ~clk_sys;

  // counts read old values at the edge, so no race with the drivers
  always @(posedge clk_sys) begin
    n_fcy += int'(fcy_tick);
    n_rc += int'(rc_tick);
    n_cpu += int'(cpu_tick);
    n_post += int'(rc_post_tick);
    fcy_tick <= tick_en & 1'($urandom % 2);
    rc_tick <= tick_en & 1'($urandom % 2);
  end

  // ----------------------------------------
  // comparison, verdict, bus tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // one-cycle write strobe; the idle edge after it keeps strobes apart
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // two key words arm exactly one following control write
  task automatic wctl(input logic hi, input logic [15:0] v);
    wr(osd_pkg::ADDR_KEY, hi ? osd_pkg::KEY_H1 : osd_pkg::KEY_L1);
    wr(osd_pkg::ADDR_KEY, hi ? osd_pkg::KEY_H2 : osd_pkg::KEY_L2);
    wr(osd_pkg::ADDR_CTL, v);
  endtask : wctl

  function automatic logic [15:0] cw(input logic [2:0] c, input logic [2:0] n, input logic [7:0] lo);
    return {1'b0, c, 1'b0, n, lo};
  endfunction : cw

  // output ticks expected from n input ticks at a power-of-two code
  function automatic int ratio_exp(input int n, input logic [2:0] c, input bit top);
    return (top && c == 3'h7) ? n / 256 : n >> c;
  endfunction : ratio_exp

  // new-source clock pulses, slow enough for the synchroniser
  task automatic edges(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys);
      new_src_clk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      new_src_clk <= 1'b0;
    end
  endtask : edges

  task automatic wait_req();
    for (int i = 0; i < 40; i++) begin
      rd(osd_pkg::ADDR_CTL);
      if (d[0] === 1'b0) return;
    end
    fail_count++;
    complete_run();
  endtask : wait_req

  task automatic irq();
    @(posedge clk_sys);
    irq_event <= 1'b1;
    @(posedge clk_sys);
    irq_event <= 1'b0;
  endtask : irq

  task automatic do_reset(input osd_pkg::osd_cfg_t c);
    rstn <= 1'b0;
    cfg <= c;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask : do_reset

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1a5d));
    do_reset({osd_pkg::SRC_RCDIVN, osd_pkg::PM_MED, osd_pkg::MON_BOTH});
    // ratios 1:1 straight after reset
    tick_en <= 1'b1;
    repeat (64) @(posedge clk_sys);
    tick_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(16'(n_cpu), 16'(n_fcy));
    chk(16'(n_post), 16'(n_rc));
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h7, 3'h7, 8'h00));
    rd(osd_pkg::ADDR_DIV);
    chk(d, 16'h3000);
    rd(osd_pkg::ADDR_KEY);
    chk(d, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk(d, 16'h0000);
    // unlocked and locked low-byte writes
    wr(osd_pkg::ADDR_CTL, 16'h0042);
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h7, 3'h7, 8'h00));
    wctl(1'b0, 16'hFFF2);
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h7, 3'h7, 8'hC2));
    chk(16'(remap_wr_ok), 16'h0000);
    chk(16'(clk_out.sec_en), 16'h0001);
    wctl(1'b0, 16'h0000);
    rd(osd_pkg::ADDR_CTL);
    chk(16'(remap_wr_ok), 16'h0001);
    // doze field and enable rules
    wr(osd_pkg::ADDR_DIV, 16'h0000);
    wr(osd_pkg::ADDR_DIV, 16'h0800);
    rd(osd_pkg::ADDR_DIV);
    chk(d, 16'h0000);
    dz = 3'(1 + $urandom % 7);
    fr = 3'($urandom);
    wr(osd_pkg::ADDR_DIV, {1'b1, dz, 1'b0, fr, 8'hFF});
    rd(osd_pkg::ADDR_DIV);
    chk(d, {1'b1, dz, 1'b0, fr, 8'h00});
    wr(osd_pkg::ADDR_DIV, {1'b1, dz, 1'b1, fr, 8'h00});
    wr(osd_pkg::ADDR_DIV, {1'b1, 3'h0, 1'b1, fr, 8'h00});
    rd(osd_pkg::ADDR_DIV);
    chk(d, {1'b1, dz, 1'b1, fr, 8'h00});
    irq();
    rd(osd_pkg::ADDR_DIV);
    chk(d, {1'b1, dz, 1'b0, fr, 8'h00});
    wr(osd_pkg::ADDR_DIV, {1'b0, dz, 1'b1, fr, 8'h00});
    irq();
    rd(osd_pkg::ADDR_DIV);
    chk(d, {1'b0, dz, 1'b1, fr, 8'h00});
    // reduced ratio and postscaler over a long random tick run
    f0 = n_fcy;
    c0 = n_cpu;
    r0 = n_rc;
    p0 = n_post;
    tick_en <= 1'b1;
    repeat (2048) @(posedge clk_sys);
    tick_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(16'(n_cpu - c0), 16'(ratio_exp(n_fcy - f0, dz, 1'b0)));
    chk(16'(n_post - p0), 16'(ratio_exp(n_rc - r0, fr, 1'b1)));
    // switch to the primary crystal, checked before the tenth edge
    wctl(1'b1, 16'h0200);
    wctl(1'b0, 16'h0001);
    edges(9);
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h7, 3'h2, 8'h01));
    edges(1);
    wait_req();
    chk(d, cw(3'h2, 3'h2, 8'h00));
    chk(16'(clk_out.src), 16'h0002);
    // same-source request aborts
    wctl(1'b0, 16'h0001);
    repeat (4) @(posedge clk_sys);
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h2, 3'h2, 8'h00));
    // failure falls back to fast RC and traps
    clk_fail_pin <= 1'b1;
    k = 0;
    while (fail_trap !== 1'b1 && k < 10) begin
      @(posedge clk_sys);
      k++;
    end
    chk(16'(k < 10), 16'h0001);
    if (k >= 10) complete_run();
    rd(osd_pkg::ADDR_CTL);
    chk({d[14:12], d[3]}, 16'h0001);
    clk_fail_pin <= 1'b0;
    wctl(1'b0, 16'h0000);
    rd(osd_pkg::ADDR_CTL);
    chk(16'(d[3]), 16'h0000);
    // primary with multiplier, switching only, clock lock set
    pll_lock_pin <= 1'b1;
    do_reset({osd_pkg::SRC_PRIPLL, osd_pkg::PM_MED, osd_pkg::MON_SW_ONLY});
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h3, 3'h3, 8'h20));
    chk(16'(clk_out.pll_en), 16'h0001);
    chk(16'(clk_out.submode), 16'(osd_pkg::PM_MED));
    wctl(1'b0, 16'h0080);
    wctl(1'b1, 16'h0000);
    wctl(1'b0, 16'h0081);
    repeat (4) @(posedge clk_sys);
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h3, 3'h0, 8'hA0));
    // switching disabled by the settings
    do_reset({osd_pkg::SRC_RCDIVN, osd_pkg::PM_EXT, 2'h3});
    wctl(1'b1, 16'h0000);
    wctl(1'b0, 16'h0001);
    repeat (4) @(posedge clk_sys);
    rd(osd_pkg::ADDR_CTL);
    chk(d, cw(3'h7, 3'h7, 8'h00));
    complete_run();
  end
endmodule : testbench
